// file: core/psr_regs.sv
// Strap status, checker counters, MAC clock delay and serial mode registers.
// Assumes a classic Wishbone master on i_clk and checker strobes on i_clk.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/100ps
`include "psr_consts.svh"
module psr_regs #(
  parameter int PKT_W = 16
) (
  input  wire logic                i_clk,             // 40 MHz core clock
  input  wire logic                i_resetn,          // Async reset, active low
  input  wire logic                i_ce,              // Clock enable, freezes all
  input  wire psr_pkg::psr_wb_req_s i_wb,             // Wishbone request
  output logic              [31:0] o_wb_dat,          // Wishbone read data
  output logic                     o_wb_ack,          // Wishbone ack
  input  wire psr_pkg::psr_strap_s i_strap,           // Strap pins, async
  input  wire logic                i_chk_byte,        // Checker byte seen
  input  wire logic                i_chk_err,         // Checker errored byte
  input  wire logic                i_chk_pkt,         // Checker packet seen
  output logic               [3:0] o_tx_delay_code,   // Transmit clock delay code
  output logic               [3:0] o_rx_delay_code,   // Receive clock delay code
  output logic                     o_six_wire_en,     // Differential clock to MAC
  output logic                     o_fast_link_detect, // Latched fast-link strap
  output logic                     o_irq              // Level interrupt
);
  import psr_pkg::*;

  psr_state_s  st_ff;
  psr_state_s  nxt_st;
  logic [9:0]  idx;
  logic        go;
  logic        wr_go;
  logic        rd_go;
  logic        lo_we;
  logic        hi_we;
  logic        lock_wr;
  logic        clr_wr;
  logic [15:0] rd_val;
  logic [15:0] byte_cnt;
  logic [7:0]  err_cnt;
  logic        byte_ovf_p;
  logic        err_ovf_p;
  logic        pkt_ovf_p;
  logic        wrap;

  // Bus decode; a new request only while no ack is out
  assign idx   = i_wb.adr[11:2];
  assign go    = i_wb.cyc & i_wb.stb & ~st_ff.ack;
  assign wr_go = go & i_wb.we;
  assign rd_go = go & ~i_wb.we;
  assign lo_we = wr_go & i_wb.sel[0];
  assign hi_we = wr_go & i_wb.sel[1];
  assign wrap  = st_ff.count_mode;

  // Writing bit 0 or bit 1 locks; bit 1 also clears
  assign lock_wr = lo_we && (idx == `PSR_IDX_CHKCS) &&
                   (i_wb.dat[`PSR_CS_LOCK] || i_wb.dat[`PSR_CS_CLEAR]);
  assign clr_wr  = lo_we && (idx == `PSR_IDX_CHKCS) &&
                   i_wb.dat[`PSR_CS_CLEAR];

  // Byte counter, live side of the snapshot
  psr_counter #(
    .W (16)
  ) u_byte_cnt (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_inc    (i_chk_byte),
    .i_clr    (clr_wr),
    .i_wrap   (wrap),
    .o_count  (byte_cnt),
    .o_ovf    (byte_ovf_p)
  );

  // Errored byte counter
  psr_counter #(
    .W (8)
  ) u_err_cnt (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_inc    (i_chk_err),
    .i_clr    (clr_wr),
    .i_wrap   (wrap),
    .o_count  (err_cnt),
    .o_ovf    (err_ovf_p)
  );

  // Packet counter, only its overflow is visible
  psr_counter #(
    .W (PKT_W)
  ) u_pkt_cnt (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_inc    (i_chk_pkt),
    .i_clr    (clr_wr),
    .i_wrap   (wrap),
    .o_count  (),
    .o_ovf    (pkt_ovf_p)
  );

  // Read mux; unmapped indices and reserved bits read zero
  always_comb begin
    rd_val = 16'h0000;
    unique case (idx)
      `PSR_IDX_STRAP2: begin
        rd_val[`PSR_FAST_LINK_DETECT_STRAP_BIT]                   = st_ff.strap_lat.fast_link_detect;
        rd_val[`PSR_STRAP_TX_LSB+2:`PSR_STRAP_TX_LSB] = st_ff.strap_lat.tx;
        rd_val[`PSR_STRAP_RX_LSB+2:`PSR_STRAP_RX_LSB] = st_ff.strap_lat.rx;
      end
      `PSR_IDX_BYTECNT: rd_val = st_ff.byte_snap;
      `PSR_IDX_CHKCS: begin
        rd_val[`PSR_CS_PKT_OVF]  = st_ff.pkt_ovf;
        rd_val[`PSR_CS_BYTE_OVF] = st_ff.byte_ovf;
        rd_val[7:0]              = st_ff.err_snap;
      end
      `PSR_IDX_SERCTL: rd_val[`PSR_SER_SIX_BIT] = st_ff.six_wire;
      `PSR_IDX_DELAY:  rd_val[7:0] = {st_ff.tx_dly, st_ff.rx_dly};
      `PSR_IDX_CHKCFG: rd_val[`PSR_CFG_MODE_BIT] = st_ff.count_mode;
      `PSR_IDX_IRQSTS: rd_val[2:0] = st_ff.irq_sts;
      `PSR_IDX_IRQMSK: rd_val[2:0] = st_ff.irq_msk;
      default:         rd_val = 16'h0000;
    endcase
  end

  // Next state of the whole bank
  always_comb begin
    nxt_st = st_ff;

    // Straps pass two flops, then are caught once after reset release
    nxt_st.strap_s1 = i_strap;
    nxt_st.strap_s2 = st_ff.strap_s1;
    if (!st_ff.strap_done) begin
      nxt_st.settle = st_ff.settle + 2'h1;
      if (st_ff.settle == `PSR_SETTLE_CYC) begin
        nxt_st.strap_lat  = st_ff.strap_s2;
        nxt_st.strap_done = 1'b1;
      end
    end

    // One-cycle ack after every request; read data held in a flop
    nxt_st.ack  = go;
    nxt_st.rdat = rd_go ? rd_val : 16'h0000;

    // Delay codes: step of PSR_DLY_STEP_PS per code, upper byte ignored
    if (lo_we && idx == `PSR_IDX_DELAY) begin
      nxt_st.tx_dly = i_wb.dat[`PSR_DLY_TX_LSB+3:`PSR_DLY_TX_LSB];
      nxt_st.rx_dly = i_wb.dat[`PSR_DLY_RX_LSB+3:`PSR_DLY_RX_LSB];
    end

    // Only bit 14 of the serial control is writable
    if (hi_we && idx == `PSR_IDX_SERCTL) begin
      nxt_st.six_wire = i_wb.dat[`PSR_SER_SIX_BIT];
    end

    // Count mode lives in a configuration register of its own
    if (lo_we && idx == `PSR_IDX_CHKCFG) begin
      nxt_st.count_mode = i_wb.dat[`PSR_CFG_MODE_BIT];
    end

    // Snapshot takes the counts before a same-edge clear
    if (lock_wr) begin
      nxt_st.byte_snap = byte_cnt;
      nxt_st.err_snap  = err_cnt;
    end

    // Overflow flags: set after the clear, but the counters drop any overflow on a clear edge
    if (clr_wr) begin
      nxt_st.pkt_ovf  = 1'b0;
      nxt_st.byte_ovf = 1'b0;
    end
    if (pkt_ovf_p) begin
      nxt_st.pkt_ovf = 1'b1;
    end
    if (byte_ovf_p) begin
      nxt_st.byte_ovf = 1'b1;
    end

    // Sticky interrupt status, write one to clear, set wins
    if (lo_we && idx == `PSR_IDX_IRQSTS) begin
      nxt_st.irq_sts = st_ff.irq_sts & ~i_wb.dat[2:0];
    end
    nxt_st.irq_sts[`PSR_IRQ_ERR]      = nxt_st.irq_sts[`PSR_IRQ_ERR] | i_chk_err;
    nxt_st.irq_sts[`PSR_IRQ_BYTE_OVF] = nxt_st.irq_sts[`PSR_IRQ_BYTE_OVF] | byte_ovf_p;
    nxt_st.irq_sts[`PSR_IRQ_PKT_OVF]  = nxt_st.irq_sts[`PSR_IRQ_PKT_OVF] | pkt_ovf_p;
    if (lo_we && idx == `PSR_IDX_IRQMSK) begin
      nxt_st.irq_msk = i_wb.dat[2:0];
    end
  end

  // State register; delay codes come out of reset at 1.75 ns
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff        <= '0;
      st_ff.tx_dly <= `PSR_DLY_RST;
      st_ff.rx_dly <= `PSR_DLY_RST;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs, all straight from flops except the interrupt level
  assign o_wb_dat           = {16'h0000, st_ff.rdat};
  assign o_wb_ack           = st_ff.ack;
  assign o_tx_delay_code    = st_ff.tx_dly;
  assign o_rx_delay_code    = st_ff.rx_dly;
  assign o_six_wire_en      = st_ff.six_wire;
  assign o_fast_link_detect = st_ff.strap_lat.fast_link_detect;
  assign o_irq              = |(st_ff.irq_sts & st_ff.irq_msk);

  // Checks of the bank; the enable gates most triggers, not those of the hold, latch and mask checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_read(logic [9:0] r);
    i_ce && rd_go && idx == r;
  endsequence

  sequence s_quiet_cnt;
    i_ce && !clr_wr && !i_chk_byte;
  endsequence

  // Compare with the latch as it stood at the take edge; a read may race the latch
  a_fld_readback: assert property (s_read(`PSR_IDX_STRAP2) |=>
    o_wb_ack && o_wb_dat[10] == $past(st_ff.strap_lat.fast_link_detect))
    else $error("fast-link strap readback wrong");

  a_tx_skew_read: assert property (s_read(`PSR_IDX_STRAP2) |=>
    o_wb_dat[6:4] == $past(st_ff.strap_lat.tx))
    else $error("tx skew strap readback wrong");

  a_rx_skew_read: assert property (s_read(`PSR_IDX_STRAP2) |=>
    o_wb_dat[2:0] == $past(st_ff.strap_lat.rx) && o_wb_dat[15:11] == 5'h00)
    else $error("rx skew strap readback wrong");

  a_byte_count_step: assert property (
    i_ce && i_chk_byte && !clr_wr && byte_cnt != 16'hFFFF |=>
    byte_cnt == $past(byte_cnt) + 16'h0001)
    else $error("byte count did not advance");

  a_snap_freeze_read: assert property (
    (i_ce && lock_wr |=> st_ff.byte_snap == $past(byte_cnt)) and
    (!(i_ce && lock_wr) |=> $stable(st_ff.byte_snap)) and
    (s_read(`PSR_IDX_BYTECNT) |=> o_wb_dat[15:0] == $past(st_ff.byte_snap)))
    else $error("byte snapshot not frozen");

  a_byte_saturate: assert property (
    i_ce && !wrap && !clr_wr && byte_cnt == 16'hFFFF |=> byte_cnt == 16'hFFFF)
    else $error("byte count left saturation");

  a_pkt_ovf_flag: assert property (
    (i_ce && pkt_ovf_p |=> st_ff.pkt_ovf) and
    (st_ff.pkt_ovf && !clr_wr |=> st_ff.pkt_ovf))
    else $error("packet overflow flag wrong");

  a_byte_ovf_flag: assert property (
    (i_ce && byte_ovf_p |=> st_ff.byte_ovf) and
    (st_ff.byte_ovf && !clr_wr |=> st_ff.byte_ovf))
    else $error("byte overflow flag wrong");

  a_err_snap_lock: assert property (
    (i_ce && lock_wr |=> st_ff.err_snap == $past(err_cnt)) and
    (!(i_ce && lock_wr) |=> $stable(st_ff.err_snap)))
    else $error("error snapshot not taken");

  a_err_saturate: assert property (
    i_ce && !wrap && !clr_wr && err_cnt == 8'hFF |=> err_cnt == 8'hFF)
    else $error("error count left saturation");

  a_lock_keeps_count: assert property (
    i_ce && lock_wr && !clr_wr && !i_chk_byte |=> byte_cnt == $past(byte_cnt))
    else $error("lock disturbed the count");

  a_clear_all: assert property (
    (i_ce && clr_wr |=> byte_cnt == 16'h0000 && err_cnt == 8'h00 &&
      !st_ff.byte_ovf && !st_ff.pkt_ovf) and
    (i_ce && clr_wr ##1 s_quiet_cnt [*2] |=> byte_cnt == 16'h0000))
    else $error("lock-and-clear left a count");

  a_tx_delay_write: assert property (
    i_ce && lo_we && idx == `PSR_IDX_DELAY |=>
    o_tx_delay_code == $past(i_wb.dat[7:4]))
    else $error("tx delay code not written");

  a_rx_delay_write: assert property (
    i_ce && lo_we && idx == `PSR_IDX_DELAY |=>
    o_rx_delay_code == $past(i_wb.dat[3:0]))
    else $error("rx delay code not written");

  a_reserved_zero: assert property (
    (s_read(`PSR_IDX_DELAY) |=> o_wb_dat[31:8] == 24'h000000) and
    (s_read(`PSR_IDX_SERCTL) |=> !o_wb_dat[15] && o_wb_dat[13:0] == 14'h0000))
    else $error("reserved bits not zero");

  a_six_wire_sel: assert property (
    i_ce && hi_we && idx == `PSR_IDX_SERCTL |=>
    o_six_wire_en == $past(i_wb.dat[14]) ##1 !i_ce || o_six_wire_en == $past(o_six_wire_en))
    else $error("six-wire select wrong");

  // Bank-wide checks; a low enable must hold every flop, ack included
  a_ce_freeze: assert property (
    !i_ce |=> $stable(st_ff))
    else $error("state moved while enable low");

  a_ack_one_cycle: assert property (
    i_ce && o_wb_ack |=> !o_wb_ack)
    else $error("ack stood longer than one cycle");

  a_ack_follows_req: assert property (
    i_ce && go |=> o_wb_ack)
    else $error("request taken without ack");

  a_strap_latch_once: assert property (
    st_ff.strap_done |=> $stable(st_ff.strap_lat))
    else $error("strap latch changed after capture");

  a_delay_hold: assert property (
    !(i_ce && lo_we && idx == `PSR_IDX_DELAY) |=>
    $stable(o_tx_delay_code) && $stable(o_rx_delay_code))
    else $error("delay code changed without a write");

  a_err_irq_set: assert property (
    i_ce && i_chk_err |=> st_ff.irq_sts[`PSR_IRQ_ERR])
    else $error("errored byte did not set status");

  a_irq_masked: assert property (
    st_ff.irq_msk == 3'h0 |-> !o_irq)
    else $error("interrupt raised while fully masked");
endmodule

// file: common/psr_consts.svh
// Constants of the strap, checker and delay register bank.
// Assumes a 32-bit classic Wishbone slave; register index = byte address / 4.
`ifndef PSR_CONSTS_SVH
`define PSR_CONSTS_SVH

// Register indices
`define PSR_IDX_STRAP2   10'h06F
`define PSR_IDX_BYTECNT  10'h071
`define PSR_IDX_CHKCS    10'h072
`define PSR_IDX_SERCTL   10'h0D3
`define PSR_IDX_DELAY    10'h080
`define PSR_IDX_CHKCFG   10'h081
`define PSR_IDX_IRQSTS   10'h082
`define PSR_IDX_IRQMSK   10'h083

// Field positions
`define PSR_FAST_LINK_DETECT_STRAP_BIT 10
`define PSR_STRAP_TX_LSB  4
`define PSR_STRAP_RX_LSB  0
`define PSR_CS_PKT_OVF    10
`define PSR_CS_BYTE_OVF   9
`define PSR_CS_LOCK       0
`define PSR_CS_CLEAR      1
`define PSR_SER_SIX_BIT   14
`define PSR_DLY_TX_LSB    4
`define PSR_DLY_RX_LSB    0
`define PSR_CFG_MODE_BIT  0
`define PSR_IRQ_ERR       0
`define PSR_IRQ_BYTE_OVF  1
`define PSR_IRQ_PKT_OVF   2

// Reset values, step size and strap settle count
`define PSR_DLY_RST       4'h7
`define PSR_CNT_RST       16'h0000
`define PSR_DLY_STEP_PS   250
`define PSR_SETTLE_CYC    2'h2

`endif

// file: common/psr_pkg.sv
// Types shared by the strap, checker and delay register bank.
// Constants live in psr_consts.svh.
package psr_pkg;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } psr_wb_req_s;

  // Strap pins, also the layout of the latched copy
  typedef struct packed {
    logic       fast_link_detect;
    logic [2:0] tx;
    logic [2:0] rx;
  } psr_strap_s;

  // Whole state of the register bank
  typedef struct packed {
    psr_strap_s  strap_s1;
    psr_strap_s  strap_s2;
    psr_strap_s  strap_lat;
    logic        strap_done;
    logic [1:0]  settle;
    logic        ack;
    logic [15:0] rdat;
    logic [3:0]  tx_dly;
    logic [3:0]  rx_dly;
    logic        six_wire;
    logic        count_mode;
    logic [15:0] byte_snap;
    logic [7:0]  err_snap;
    logic        pkt_ovf;
    logic        byte_ovf;
    logic [2:0]  irq_sts;
    logic [2:0]  irq_msk;
  } psr_state_s;

endpackage

// file: core/psr_counter.sv
// Checker event counter, saturating or wrapping.
// Assumes increment and clear come from logic on the same clock.
`timescale 1ns/100ps
module psr_counter #(
  parameter int W = 16
) (
  input  wire logic         i_clk,    // Core clock
  input  wire logic         i_resetn, // Async reset, active low
  input  wire logic         i_ce,     // Clock enable
  input  wire logic         i_inc,    // Count one event
  input  wire logic         i_clr,    // Clear to zero
  input  wire logic         i_wrap,   // 1 wrap, 0 saturate
  output logic      [W-1:0] o_count,  // Current count
  output logic              o_ovf     // Overflow pulse
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } psr_cnt_s;

  psr_cnt_s cnt_ff;
  psr_cnt_s nxt_cnt;

  // Clear beats a same-cycle event: the clear is the snapshot point
  always_comb begin
    nxt_cnt = cnt_ff;
    o_ovf   = 1'b0;
    if (i_clr) begin
      nxt_cnt.cnt = '0;
    end else if (i_inc) begin
      if (&cnt_ff.cnt) begin
        o_ovf = i_ce;
        if (i_wrap) begin
          nxt_cnt.cnt = '0;
        end
      end else begin
        nxt_cnt.cnt = cnt_ff.cnt + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_ff <= '0;
    end else if (i_ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_count = cnt_ff.cnt;
endmodule

// file: test/psr_chk_model.sv
// Model of the pattern checker that feeds byte, error and packet strobes.
// Assumes burst is called right after a rising edge of i_clk.
`timescale 1ns/100ps
module psr_chk_model (
  input  wire logic i_clk,  // Core clock
  output logic      o_byte, // Byte seen strobe
  output logic      o_err,  // Errored byte strobe
  output logic      o_pkt   // Packet seen strobe
);
  // Quiet until the bench asks for traffic
  initial begin
    o_byte = 1'b0;
    o_err = 1'b0;
    o_pkt = 1'b0;
  end

  // Each strobe high for its first n events; gap idles make a slow checker
  task automatic burst(input int nb, input int ne, input int np, input int gap);
    int last;
    last = (nb > ne) ? nb : ne;
    last = (np > last) ? np : last;
    for (int i = 0; i < last; i++) begin
      o_byte <= (i < nb);
      o_err <= (i < ne);
      o_pkt <= (i < np);
      @(posedge i_clk);
      for (int g = 0; g < gap; g++) begin
        {o_byte, o_err, o_pkt} <= 3'b000;
        @(posedge i_clk);
      end
    end
    {o_byte, o_err, o_pkt} <= 3'b000;
    @(posedge i_clk);
  endtask
endmodule

// file: test/psr_regs_bench.sv
// Bench for the strap, checker and delay register bank.
// Assumes psr_chk_model drives the checker strobes on the same clock.
`timescale 1ns/100ps
`include "psr_consts.svh"
module psr_regs_bench;
  import psr_pkg::*;
  logic              i_clk;
  logic              i_resetn;
  logic              ce;
  psr_wb_req_s       wb;
  logic       [31:0] rd_dat;
  logic              ack;
  psr_strap_s        strap;
  logic              c_byte;
  logic              c_err;
  logic              c_pkt;
  logic        [3:0] tx_code;
  logic        [3:0] rx_code;
  logic              six;
  logic              fast_link_detect;
  logic              irq;
  int                n_errors;
  int                samples_checked;

  // Narrow packet counter so its overflow is reached quickly
  psr_regs #(.PKT_W(4)) u_psr_regs (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce), .i_wb(wb),
    .o_wb_dat(rd_dat), .o_wb_ack(ack), .i_strap(strap), .i_chk_byte(c_byte),
    .i_chk_err(c_err), .i_chk_pkt(c_pkt), .o_tx_delay_code(tx_code),
    .o_rx_delay_code(rx_code), .o_six_wire_en(six), .o_fast_link_detect(fast_link_detect),
    .o_irq(irq));

  psr_chk_model u_chk (.i_clk(i_clk), .o_byte(c_byte), .o_err(c_err), .o_pkt(c_pkt));

  // 40 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; request held until ack is seen at an edge
  task automatic xfer(input logic we, input logic [9:0] idx, input logic [15:0] wd,
                      output logic [15:0] q);
    wb <= '{cyc:1'b1, stb:1'b1, we:we, adr:{idx, 2'b00}, sel:4'hF, dat:{16'h0000, wd}};
    @(posedge i_clk);
    // No wait count of our own: only the hang guard ends a stuck wait
    while (ack !== 1'b1) begin
      @(posedge i_clk);
    end
    q = rd_dat[15:0];
    wb <= '0;
    @(posedge i_clk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] wd);
    logic [15:0] q;
    xfer(1'b1, idx, wd, q);
  endtask

  task automatic chk_rd(input logic [9:0] idx, input logic [15:0] exp);
    logic [15:0] q;
    xfer(1'b0, idx, 16'h0000, q);
    chk_reg(q, exp);
  endtask

  // Hang guard, well beyond the longest burst
  initial begin
    #(25 * 100000);
    n_errors++;
    results();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    samples_checked = 0;
    i_resetn = 1'b0;
    ce = 1'b1;
    wb = '0;
    strap = '{fast_link_detect:1'b1, tx:3'h5, rx:3'h2};
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk_reg({8'h00, tx_code, rx_code}, 16'h0077);
    chk_rd(`PSR_IDX_DELAY, 16'h0077);
    chk_rd(`PSR_IDX_SERCTL, 16'h0000);
    wr(`PSR_IDX_STRAP2, 16'hFFFF);
    chk_rd(`PSR_IDX_STRAP2, 16'h0452);
    chk_bit(fast_link_detect, 1'b1);
    chk_rd(`PSR_IDX_BYTECNT, 16'h0000);
    chk_rd(10'h100, 16'h0000);
    // Delay codes, serial mode and reserved bits
    wr(`PSR_IDX_DELAY, 16'hFFA5);
    chk_rd(`PSR_IDX_DELAY, 16'h00A5);
    chk_reg({8'h00, tx_code, rx_code}, 16'h00A5);
    wr(`PSR_IDX_SERCTL, 16'hFFFF);
    chk_rd(`PSR_IDX_SERCTL, 16'h4000);
    chk_bit(six, 1'b1);
    wr(`PSR_IDX_SERCTL, 16'h0000);
    chk_bit(six, 1'b0);
    // Snapshot, freeze, then lock-and-clear
    u_chk.burst(10, 3, 2, 1);
    wr(`PSR_IDX_CHKCS, 16'h0001);
    chk_rd(`PSR_IDX_BYTECNT, 16'h000A);
    chk_rd(`PSR_IDX_CHKCS, 16'h0003);
    u_chk.burst(5, 1, 0, 0);
    chk_rd(`PSR_IDX_BYTECNT, 16'h000A);
    chk_rd(`PSR_IDX_CHKCS, 16'h0003);
    wr(`PSR_IDX_CHKCS, 16'h0002);
    chk_rd(`PSR_IDX_BYTECNT, 16'h000F);
    chk_rd(`PSR_IDX_CHKCS, 16'h0004);
    // Enable low: strobes must not count
    ce <= 1'b0;
    u_chk.burst(4, 2, 1, 0);
    ce <= 1'b1;
    wr(`PSR_IDX_CHKCS, 16'h0001);
    chk_rd(`PSR_IDX_BYTECNT, 16'h0000);
    chk_rd(`PSR_IDX_CHKCS, 16'h0000);
    // Saturation and both overflow flags in count mode zero
    u_chk.burst(65537, 300, 16, 0);
    wr(`PSR_IDX_CHKCS, 16'h0001);
    chk_rd(`PSR_IDX_BYTECNT, 16'hFFFF);
    chk_rd(`PSR_IDX_CHKCS, 16'h06FF);
    wr(`PSR_IDX_CHKCS, 16'h0001);
    chk_rd(`PSR_IDX_CHKCS, 16'h06FF);
    // Error and overflow events reach the interrupt only when unmasked
    chk_rd(`PSR_IDX_IRQSTS, 16'h0007);
    chk_bit(irq, 1'b0);
    wr(`PSR_IDX_IRQMSK, 16'h0007);
    chk_bit(irq, 1'b1);
    wr(`PSR_IDX_IRQSTS, 16'h0007);
    chk_bit(irq, 1'b0);
    chk_rd(`PSR_IDX_IRQSTS, 16'h0000);
    wr(`PSR_IDX_CHKCS, 16'h0002);
    chk_rd(`PSR_IDX_CHKCS, 16'h00FF);
    // Count mode one wraps the error count instead
    wr(`PSR_IDX_CHKCFG, 16'h0001);
    u_chk.burst(0, 257, 0, 0);
    wr(`PSR_IDX_CHKCS, 16'h0001);
    chk_rd(`PSR_IDX_CHKCS, 16'h0001);
    results();
  end
endmodule
